// file: rtl/scd_consts.svh
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH

// Register addresses
`define SCD_ADDR_EXTERNAL_INTERRUPT_FLAG_REG      8'h91
`define SCD_ADDR_PMR       8'hc4
`define SCD_ADDR_STATUS    8'hc5

// Power management field positions
`define SCD_PMR_CD_HI      7
`define SCD_PMR_CD_LO      6
`define SCD_PMR_SWB        5
`define SCD_PMR_CRYSTAL_AMP_DISABLE      3

// External interrupt flag field positions
`define SCD_EXTERNAL_INTERRUPT_FLAG_REG_XTRG      3
`define SCD_EXTERNAL_INTERRUPT_FLAG_REG_RGMD      2

// Status field positions
`define SCD_ST_PIP         7
`define SCD_ST_HIP         6
`define SCD_ST_LIP         5
`define SCD_ST_CRYSTAL_READY_FLAG        4
`define SCD_ST_SPTA        1
`define SCD_ST_SPRA        0

// Divider codes
`define SCD_CD_RSVD        2'b00
`define SCD_CD_DIV4        2'b01
`define SCD_CD_DIV64       2'b10
`define SCD_CD_DIV1024     2'b11

// Clocks per instruction cycle
`define SCD_CLK_DIV4       4
`define SCD_CLK_DIV64      64
`define SCD_CLK_DIV1024    1024

// Reset values
`define SCD_RST_CD         2'b01
`define SCD_RST_SWB        1'b0
`define SCD_RST_CRYSTAL_AMP_DISABLE      1'b0
`define SCD_RST_XTRG       1'b1
`define SCD_RST_CRYSTAL_READY_FLAG       1'b1

// Crystal warm-up, in crystal clocks
`define SCD_CRYSTAL_READY_FLAG_CLOCKS    65536
`define SCD_WARM_W         17

`endif

// file: rtl/scd_pkg.sv
package scd_pkg;

  // Register write strobe with address and data
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scd_sfr_t;

  // Interrupt controller view
  typedef struct packed {
    logic       pip;      // power-fail level in service
    logic       hip;      // high level in service
    logic       lip;      // low level in service
    logic [1:0] ext_en;   // external source enabled
    logic [1:0] ext_hi;   // external source has high priority
    logic [1:0] ext_req;  // external request pulse
  } scd_irq_t;

  // Serial port 0 view
  typedef struct packed {
    logic rx_en;      // receive enable from serial control
    logic start_det;  // start bit edge pulse
    logic rx_active;  // word being received
    logic tx_active;  // word being shifted out
  } scd_ser_t;

endpackage

// file: rtl/scd_top.sv
`timescale 1ns/1ns
`include "scd_consts.svh"

module scd_top #(
  parameter int CRYSTAL_READY_FLAG_CLOCKS = `SCD_CRYSTAL_READY_FLAG_CLOCKS
) (
  // Clock, reset, enable
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             ce_i,
  // Register port
  input  wire scd_pkg::scd_sfr_t sfr_i,
  output logic [7:0]            sfr_rdata_o,
  // Interrupt controller and serial port 0
  input  wire scd_pkg::scd_irq_t irq_i,
  input  wire scd_pkg::scd_ser_t ser_i,
  // Clock control outputs
  output logic                  cycle_tick_o,
  output logic [1:0]            active_div_o,
  output logic                  osc_select_xtal_o,
  output logic                  crystal_amp_disable_o,
  output logic                  auto_return_o
);

  // Last count value of a divider code
  // four clock default
  function automatic logic [9:0] div_last(input logic [1:0] cd);
    logic [9:0] r;
    r = 10'(`SCD_CLK_DIV4 - 1);
    unique case (cd)
      `SCD_CD_DIV64:   r = 10'(`SCD_CLK_DIV64 - 1);
      `SCD_CD_DIV1024: r = 10'(`SCD_CLK_DIV1024 - 1);
      default:         r = 10'(`SCD_CLK_DIV4 - 1);
    endcase
    return r;
  endfunction

  // State
  logic [1:0]  cd_q;          // software divider field
  logic [1:0]  active_q;      // divider in force
  logic [9:0]  cnt_q;
  logic        swb_q;
  logic        crystal_amp_disable_q;
  logic        xtrg_q;        // requested source, 1 crystal
  logic        rgmd_q;        // source in force, 1 ring
  logic        crystal_ready_flag_q;
  logic [`SCD_WARM_W-1:0] warm_q;
  logic        start_seen_q;
  logic [7:0]  rdata_q;

  // Address decode
  wire wr_external_interrupt_flag_reg = sfr_i.wr && (sfr_i.addr == `SCD_ADDR_EXTERNAL_INTERRUPT_FLAG_REG);
  wire wr_pmr  = sfr_i.wr && (sfr_i.addr == `SCD_ADDR_PMR);
  wire [1:0] cd_new = sfr_i.wdata[`SCD_PMR_CD_HI:`SCD_PMR_CD_LO];

  // Interrupt qualification by service level
  logic [1:0] irq_ok;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_irq
      assign irq_ok[g] = irq_i.ext_req[g] && irq_i.ext_en[g] && !irq_i.pip
                         && !irq_i.hip && (irq_i.ext_hi[g] || !irq_i.lip);
    end
  endgenerate

  // Switchback triggers
  // interrupt trigger
  wire irq_trig   = |irq_ok;
  wire start_trig = ser_i.start_det && ser_i.rx_en;
  wire sb_trig    = swb_q && (irq_trig || start_trig);

  // Divider write qualification
  // serial busy lock
  wire ser_lock   = ser_i.rx_active || ser_i.tx_active;
  wire start_lock = swb_q && (start_seen_q || ser_i.start_det);
  wire slow_ok    = (cd_q == `SCD_CD_DIV4) && !ser_lock && !start_lock;
  wire cd_wr_ok   = wr_pmr && (cd_new != `SCD_CD_RSVD) &&
                    ((cd_new == `SCD_CD_DIV4) || slow_ok);

  wire [1:0] cd_d = sb_trig  ? `SCD_CD_DIV4 :
                    cd_wr_ok ? cd_new : cd_q;

  // Tick generation
  // shared tick
  wire tick = ce_i && (cnt_q == div_last(active_q));
  assign cycle_tick_o = tick;

  // Crystal source and amplifier writes
  wire xtrg_new   = sfr_i.wdata[`SCD_EXTERNAL_INTERRUPT_FLAG_REG_XTRG];
  wire crystal_amp_disable_new  = sfr_i.wdata[`SCD_PMR_CRYSTAL_AMP_DISABLE];
  wire xtrg_set_ok = crystal_ready_flag_q && !crystal_amp_disable_q;
  wire xtrg_d = (wr_external_interrupt_flag_reg && (!xtrg_new || xtrg_set_ok)) ? xtrg_new : xtrg_q;
  // Amplifier may be disabled only on ring request
  wire crystal_amp_disable_d = (wr_pmr && (!crystal_amp_disable_new || !xtrg_q)) ? crystal_amp_disable_new : crystal_amp_disable_q;
  wire warm_done = (warm_q == `SCD_WARM_W'(CRYSTAL_READY_FLAG_CLOCKS - 1));

  // Read mux
  logic [7:0] external_interrupt_flag_reg_rd;
  logic [7:0] pmr_rd;
  logic [7:0] stat_rd;
  always_comb begin
    external_interrupt_flag_reg_rd = 8'h00;
    external_interrupt_flag_reg_rd[`SCD_EXTERNAL_INTERRUPT_FLAG_REG_XTRG] = xtrg_q;
    external_interrupt_flag_reg_rd[`SCD_EXTERNAL_INTERRUPT_FLAG_REG_RGMD] = rgmd_q;
    pmr_rd = 8'h00;
    pmr_rd[`SCD_PMR_CD_HI:`SCD_PMR_CD_LO] = cd_q;
    pmr_rd[`SCD_PMR_SWB]   = swb_q;
    pmr_rd[`SCD_PMR_CRYSTAL_AMP_DISABLE] = crystal_amp_disable_q;
    stat_rd = 8'h00;
    stat_rd[`SCD_ST_PIP]  = irq_i.pip;
    stat_rd[`SCD_ST_HIP]  = irq_i.hip;
    stat_rd[`SCD_ST_LIP]  = irq_i.lip;
    stat_rd[`SCD_ST_CRYSTAL_READY_FLAG] = crystal_ready_flag_q;
    stat_rd[`SCD_ST_SPTA] = ser_i.tx_active;
    stat_rd[`SCD_ST_SPRA] = ser_i.rx_active;
  end

  wire [7:0] rd_mux = (sfr_i.addr == `SCD_ADDR_EXTERNAL_INTERRUPT_FLAG_REG)   ? external_interrupt_flag_reg_rd :
                      (sfr_i.addr == `SCD_ADDR_PMR)    ? pmr_rd  :
                      (sfr_i.addr == `SCD_ADDR_STATUS) ? stat_rd : 8'h00;

  // Divider field and enable bit
  // reset values
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cd_q  <= `SCD_RST_CD;
      swb_q <= `SCD_RST_SWB;
    end else if (ce_i) begin
      cd_q <= cd_d;
      if (wr_pmr) begin
        swb_q <= sfr_i.wdata[`SCD_PMR_SWB];
      end
    end
  end

  // Divider in force and cycle counter
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_q <= `SCD_RST_CD;
      cnt_q    <= 10'h000;
    end else if (ce_i) begin
      if (sb_trig) begin
        active_q <= `SCD_CD_DIV4;
        cnt_q    <= 10'h000;
      end else if (tick) begin
        active_q <= cd_q;
        cnt_q    <= 10'h000;
      end else begin
        cnt_q <= cnt_q + 10'h001;
      end
    end
  end

  // Clock source select, taken over at the next tick
  // independent source control
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xtrg_q  <= `SCD_RST_XTRG;
      rgmd_q  <= 1'b0;
      crystal_amp_disable_q <= `SCD_RST_CRYSTAL_AMP_DISABLE;
    end else if (ce_i) begin
      xtrg_q  <= xtrg_d;
      crystal_amp_disable_q <= crystal_amp_disable_d;
      if (tick) begin
        rgmd_q <= !xtrg_q;
      end
    end
  end

  // Crystal warm-up counter
  // warm-up wait
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      crystal_ready_flag_q <= `SCD_RST_CRYSTAL_READY_FLAG;
      warm_q <= '0;
    end else if (ce_i) begin
      if (crystal_amp_disable_q) begin
        crystal_ready_flag_q <= 1'b0;
        warm_q <= '0;
      end else if (!crystal_ready_flag_q) begin
        crystal_ready_flag_q <= warm_done;
        warm_q <= warm_done ? '0 : warm_q + `SCD_WARM_W'(1);
      end
    end
  end

  // Start bit memory until serial port idles
  // start bit held
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_seen_q <= 1'b0;
    end else if (ce_i) begin
      if (ser_i.start_det && swb_q) begin
        start_seen_q <= 1'b1;
      end else if (!ser_lock) begin
        start_seen_q <= 1'b0;
      end
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      rdata_q <= rd_mux;
    end
  end

  // Outputs
  // same divider on either source
  assign active_div_o          = active_q;
  assign osc_select_xtal_o     = !rgmd_q;
  assign crystal_amp_disable_o = crystal_amp_disable_q;
  assign auto_return_o         = swb_q;
  assign sfr_rdata_o           = rdata_q;

  // Checks
  cd_never_rsvd_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    cd_q != `SCD_CD_RSVD)
    else $error("divider field holds reserved code");

  slow_from4_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $changed(cd_q) && cd_q != `SCD_CD_DIV4 |-> $past(cd_q) == `SCD_CD_DIV4)
    else $error("reduced rate entered from a reduced rate");

  hw_no_slow_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $changed(cd_q) && cd_q != `SCD_CD_DIV4 |-> $past(wr_pmr && ce_i))
    else $error("reduced rate without software write");

  sb_restore_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && sb_trig |=> cd_q == `SCD_CD_DIV4 && active_q == `SCD_CD_DIV4
                        && cnt_q == 10'h000)
    else $error("switchback did not restore four clocks");

  busy_lock_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && wr_pmr && ser_lock && cd_q == `SCD_CD_DIV4
    |=> cd_q == `SCD_CD_DIV4)
    else $error("divider changed while serial port busy");

  src_keep_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && sb_trig && !wr_external_interrupt_flag_reg |=> $stable(xtrg_q))
    else $error("switchback altered clock source");

  xtal_guard_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(xtrg_q) |-> $past(crystal_ready_flag_q) && !$past(crystal_amp_disable_q))
    else $error("crystal selected before ready");

  div_delay_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $changed(active_q) && !$past(sb_trig && ce_i) |-> $past(tick))
    else $error("divider changed off cycle boundary");

  tick_gap_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    tick && cd_q == `SCD_CD_DIV4 && !sb_trig
    ##1 (ce_i && !sb_trig) [*3] ##1 ce_i |-> tick)
    else $error("four clock cycle period wrong");

  hip_lockout_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && irq_i.hip && !start_trig && !cd_wr_ok |=> $stable(cd_q))
    else $error("interrupt under high service changed divider");

  start_lock_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && wr_pmr && start_lock && cd_q == `SCD_CD_DIV4
    |=> cd_q == `SCD_CD_DIV4)
    else $error("reduced rate taken after start bit");

  swb_gate_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !swb_q && !cd_wr_ok && ce_i |=> $stable(cd_q))
    else $error("hardware changed divider while auto-return off");

  // Main scenarios
  cov_slow64_c: cover property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    active_q == `SCD_CD_DIV64 && tick);
  cov_sb_irq_c: cover property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && swb_q && irq_trig && cd_q == `SCD_CD_DIV1024);
  cov_sb_start_c: cover property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && swb_q && start_trig && cd_q != `SCD_CD_DIV4);
  cov_warm_c: cover property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(crystal_ready_flag_q));
  cov_lock_c: cover property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && wr_pmr && ser_lock);

endmodule

// file: bench/scd_far_model.sv
`timescale 1ns/1ns
// Interrupt controller and serial port 0 stand-in
module scd_far_model (
  // Clock
  input  wire logic         ref_clk_i,
  // Views handed to the clock block
  output scd_pkg::scd_irq_t irq_o,
  output scd_pkg::scd_ser_t ser_o
);
  // Idle levels until told otherwise
  initial begin
    irq_o = '0;
    ser_o = '0;
  end

  // In-service levels, source enables and priorities
  task automatic set_irq(input logic [2:0] lvl, input logic [1:0] en,
                         input logic [1:0] hi);
    {irq_o.pip, irq_o.hip, irq_o.lip} = lvl;
    irq_o.ext_en = en;
    irq_o.ext_hi = hi;
  endtask

  // Receive enable and word activity levels
  task automatic set_ser(input logic en, input logic rx, input logic tx);
    ser_o.rx_en     = en;
    ser_o.rx_active = rx;
    ser_o.tx_active = tx;
  endtask

  // One-cycle request, launched and dropped on falling edges
  task automatic ext_pulse(input int g);
    irq_o.ext_req[g] = 1'b1;
    @(negedge ref_clk_i);
    irq_o.ext_req = '0;
  endtask

  // One-cycle start bit edge
  task automatic start_pulse();
    ser_o.start_det = 1'b1;
    @(negedge ref_clk_i);
    ser_o.start_det = 1'b0;
  endtask
endmodule

// file: bench/scd_top_tb.sv
`timescale 1ns/1ns
`include "scd_consts.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); \
  bad_count++; end end

module scd_top_tb;
  localparam int CRYSTAL_READY_FLAG = 8;
  localparam logic [7:0] POWER_MANAGEMENT_REG = `SCD_ADDR_PMR;
  localparam logic [7:0] EXI = `SCD_ADDR_EXTERNAL_INTERRUPT_FLAG_REG;
  localparam logic [7:0] STA = `SCD_ADDR_STATUS;

  logic              ref_clk_i;
  logic              reset_n_i;
  logic              ce_i;
  scd_pkg::scd_sfr_t sfr_i;
  scd_pkg::scd_irq_t irq_i;
  scd_pkg::scd_ser_t ser_i;
  logic [7:0]        sfr_rdata_o;
  logic              cycle_tick_o;
  logic [1:0]        active_div_o;
  logic              osc_select_xtal_o;
  logic              crystal_amp_disable_o;
  logic              auto_return_o;
  int                bad_count;
  int                checks_done;

  // Design under test with a short crystal warm-up
  scd_top #(.CRYSTAL_READY_FLAG_CLOCKS(CRYSTAL_READY_FLAG)) uut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .sfr_i(sfr_i), .sfr_rdata_o(sfr_rdata_o), .irq_i(irq_i),
    .ser_i(ser_i), .cycle_tick_o(cycle_tick_o),
    .active_div_o(active_div_o), .osc_select_xtal_o(osc_select_xtal_o),
    .crystal_amp_disable_o(crystal_amp_disable_o),
    .auto_return_o(auto_return_o));

  // Far side stand-in
  scd_far_model far (.ref_clk_i(ref_clk_i), .irq_o(irq_i), .ser_o(ser_i));

  // Clock of 10 ns period
  always #5 ref_clk_i = ~ref_clk_i;

  // One register write, strobe held for one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    sfr_i = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge ref_clk_i);
    sfr_i.wr = 1'b0;
  endtask

  // Register read, data registered one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk_i);
    sfr_i.addr = a;
    @(negedge ref_clk_i);
    `CHK(sfr_rdata_o, e)
  endtask

  // Align to a tick, then count the cycles to the next one
  task automatic per(input int e);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    while (cycle_tick_o !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (cycle_tick_o !== 1'b1 && n < 3000);
    `CHK(n, e)
  endtask

  // Verdict and end of run
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    bad_count++;
    conclude();
  end

  // Main sequence
  initial begin
    ref_clk_i = 1'b0;
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    sfr_i = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (2) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    // Reset values and register map
    rd(POWER_MANAGEMENT_REG, 8'h40);
    rd(EXI, 8'h08);
    rd(STA, 8'h10);
    rd(8'h00, 8'h00);
    per(4);
    // Reserved code and reduced rates
    wr(POWER_MANAGEMENT_REG, 8'h00);
    rd(POWER_MANAGEMENT_REG, 8'h40);
    wr(POWER_MANAGEMENT_REG, 8'h80);
    `CHK(active_div_o, 2'b01)
    per(64);
    `CHK(active_div_o, 2'b10)
    wr(POWER_MANAGEMENT_REG, 8'hc0);
    rd(POWER_MANAGEMENT_REG, 8'h80);
    wr(POWER_MANAGEMENT_REG, 8'h40);
    per(4);
    wr(POWER_MANAGEMENT_REG, 8'hc0);
    per(1024);
    `CHK(active_div_o, 2'b11)
    wr(POWER_MANAGEMENT_REG, 8'h40);
    per(4);
    // Ring source, then crystal off
    wr(EXI, 8'h00);
    per(4);
    rd(EXI, 8'h04);
    `CHK(osc_select_xtal_o, 1'b0)
    wr(POWER_MANAGEMENT_REG, 8'h48);
    `CHK(crystal_amp_disable_o, 1'b1)
    rd(STA, 8'h00);
    wr(EXI, 8'h08);
    rd(EXI, 8'h04);
    // External switchback with priority lockout
    far.set_irq(3'b010, 2'b01, 2'b00);
    rd(STA, 8'h40);
    wr(POWER_MANAGEMENT_REG, 8'ha8);
    far.ext_pulse(0);
    rd(POWER_MANAGEMENT_REG, 8'ha8);
    far.set_irq(3'b000, 2'b01, 2'b00);
    far.ext_pulse(0);
    rd(POWER_MANAGEMENT_REG, 8'h68);
    `CHK(auto_return_o, 1'b1)
    `CHK(active_div_o, 2'b01)
    `CHK(osc_select_xtal_o, 1'b0)
    wr(POWER_MANAGEMENT_REG, 8'h88);
    far.ext_pulse(0);
    rd(POWER_MANAGEMENT_REG, 8'h88);
    // Serial start bit switchback and write lockouts
    wr(POWER_MANAGEMENT_REG, 8'h48);
    far.set_ser(1'b1, 1'b0, 1'b0);
    wr(POWER_MANAGEMENT_REG, 8'ha8);
    far.start_pulse();
    rd(POWER_MANAGEMENT_REG, 8'h68);
    far.set_ser(1'b1, 1'b1, 1'b0);
    wr(POWER_MANAGEMENT_REG, 8'ha8);
    rd(POWER_MANAGEMENT_REG, 8'h68);
    far.set_ser(1'b1, 1'b0, 1'b1);
    wr(POWER_MANAGEMENT_REG, 8'h48);
    wr(POWER_MANAGEMENT_REG, 8'h88);
    rd(POWER_MANAGEMENT_REG, 8'h48);
    far.set_ser(1'b0, 1'b0, 1'b0);
    wr(POWER_MANAGEMENT_REG, 8'ha8);
    far.start_pulse();
    rd(POWER_MANAGEMENT_REG, 8'ha8);
    // Back to full speed on the crystal
    wr(POWER_MANAGEMENT_REG, 8'h40);
    repeat (CRYSTAL_READY_FLAG + 4) @(negedge ref_clk_i);
    rd(STA, 8'h10);
    wr(EXI, 8'h08);
    per(4);
    rd(EXI, 8'h08);
    `CHK(osc_select_xtal_o, 1'b1)
    conclude();
  end
endmodule
